// *** tim_cfg.svh ***
// Register offsets, field positions and timing counts for the interrupt masks
`ifndef TIM_CFG_SVH
`define TIM_CFG_SVH
`define TIM_ADDR_MASK1 5'h1c
`define TIM_ADDR_MASK2 5'h1d
`define TIM_ADDR_MASK3 5'h1e
`define TIM_ADDR_RESET_CTRL 5'h1a
`define TIM_BIT_SUSPEND 6
`define TIM_BIT_ACK 5
`define TIM_MASK_RESET 8'h00
`define TIM_MASK3_USED 8'h1f
`define TIM_MASK1_USED 8'hfe
`define TIM_LOOP_TIME_MS 48
`define TIM_CLK_MHZ 125
`define TIM_LOOP_CYCLES (`TIM_LOOP_TIME_MS * 1000 * `TIM_CLK_MHZ)
`define TIM_BOM_WINDOW 10
`define TIM_BOM_ACCEPT 8
`define TIM_PD_MAX_N 23
`endif

// *** tim_pkg.sv ***
// Types shared by the interrupt mask files
package tim_pkg;
  typedef logic [7:0] tim_byte_t;
  typedef enum logic [2:0] {
    TIM_LC_IDLE = 3'b001,
    TIM_LC_TIMING = 3'b010,
    TIM_LC_DONE = 3'b100
  } tim_lc_state_t;
endpackage : tim_pkg

// *** tim_bom_filter.sv ***
// Bit-oriented message acceptance filter, 8 of the last 10 positions
`timescale 1ns/1ps
`default_nettype none
`include "tim_cfg.svh"
module tim_bom_filter
  import tim_pkg::*;
#(
  parameter int WIN = `TIM_BOM_WINDOW,
  parameter int ACC = `TIM_BOM_ACCEPT
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic msg_valid,
  input wire logic [5:0] msg_code,
  output logic new_msg
);
  initial
  begin
    if (ACC > WIN || ACC < 1 || WIN > 16)
      $error("tim_bom_filter: bad window parameters");
  end

  logic [5:0] hist_q [WIN];
  logic [5:0] accepted_q;
  logic have_q;
  logic new_q;
  logic [4:0] match_cnt;
  logic [5:0] newest;

  // Count recent positions equal to the newest code
  always_comb
  begin
    match_cnt = 5'h00;
    newest = msg_code;
    for (int i = 0; i < WIN - 1; i++)
      if (hist_q[i] == newest)
        match_cnt = match_cnt + 5'h01;
    match_cnt = match_cnt + 5'h01;
  end

  // History shift and acceptance of a differing message
  always_ff @(posedge clk_sys)
  begin
    new_q <= 1'b0;
    if (srst)
    begin
      for (int i = 0; i < WIN; i++)
        hist_q[i] <= 6'h00;
      accepted_q <= 6'h00;
      have_q <= 1'b0;
    end
    else if (msg_valid)
    begin
      hist_q[0] <= msg_code;
      for (int i = 1; i < WIN; i++)
        hist_q[i] <= hist_q[i-1];
      if (match_cnt >= 5'(ACC) && (!have_q || msg_code != accepted_q))
      begin
        accepted_q <= msg_code;
        have_q <= 1'b1;
        new_q <= 1'b1;
      end
    end
  end
  assign new_msg = new_q;
endmodule : tim_bom_filter
`default_nettype wire

// *** tim_irq_masks.sv ***
// T1 event interrupt masking with pending flags and open-drain interrupt
`timescale 1ns/1ps
`default_nettype none
`include "tim_cfg.svh"
// Functional notes
// - Mask one enables, zero suppresses source
// - Framing bit error only in terminal sync
// - Interrupt on each local check error
// - Interrupt on received remote alarm
// - Interrupt on alignment change after reframe
// - Bipolar violation, excluding substitution code
// - Test sequence bit error interrupt
// - Pulse density or zeros violation interrupt
// - Six error counters wrap interrupt
// - Test sequence multiframe counter overflow
// - Multiframe sync loss counter wraps
// - Loop code held 48 ms interrupts
// - One second status rising edge
// - Five second status rising edge
// - New differing bit message interrupt
// - Message accepted at 8 of 10
// - Signaling change, optionally debounced
// - Acknowledge clears status, releases, self-clears
// - Suspend releases output, ignores sources
module tim_irq_masks
  import tim_pkg::*;
#(
  parameter int LOOP_CYCLES = `TIM_LOOP_CYCLES,
  parameter int CNT_W = 8
)
(
  input wire logic clk_sys,
  input wire logic srst,
  // Parallel register port, same clock
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Line event pulses from the receive detectors
  input wire logic frame_bit_err,
  input wire logic term_frame_sync,
  input wire logic check_err,
  input wire logic remote_alarm,
  input wire logic align_change,
  input wire logic bipolar_viol,
  input wire logic bipolar_subst,
  input wire logic test_seq_err,
  input wire logic zeros_excess,
  input wire logic [4:0] density_n,
  input wire logic density_one,
  input wire logic density_bit,
  // Counter increment strobes, counters kept here for wrap sensing
  input wire logic [5:0] err_cnt_inc,
  input wire logic test_seq_mf_inc,
  input wire logic mf_sync_loss_inc,
  input wire logic cnt_clear,
  // Timer, loop code, message and signaling inputs
  input wire logic loop_code_seen,
  input wire logic one_second_tick,
  input wire logic five_second_tick,
  input wire logic msg_valid,
  input wire logic [5:0] msg_code,
  input wire logic signaling_change,
  input wire logic signaling_change_db,
  input wire logic signaling_debounce_en,
  // Interrupt pin, open drain, active low
  output logic irq_n_o,
  output logic irq_n_oe
);
  initial
  begin
    if (CNT_W < 2 || LOOP_CYCLES < 1)
      $error("tim_irq_masks: bad parameters");
  end

  tim_byte_t mask1_q, mask2_q, mask3_q;
  logic irq_suspend_q, irq_acknowledge_q;
  tim_byte_t pend1_q, pend2_q, pend3_q;
  tim_byte_t ev1, ev2, ev3;
  logic [CNT_W-1:0] cnt_q [8];
  logic [7:0] cnt_inc, cnt_wrap;
  logic one_sec_q, five_sec_q;
  logic one_sec_rise, five_sec_rise;
  tim_lc_state_t lc_q;
  logic [31:0] lc_cnt_q;
  logic loop_fire;
  logic bom_new;
  logic [4:0] dens_ones_q;
  logic [7:0] dens_bits_q;
  logic dens_viol;
  logic wr_m1, wr_m2, wr_m3, wr_rc;
  logic pending;

  // Write decode
  assign wr_m1 = reg_wr && reg_addr == `TIM_ADDR_MASK1;
  assign wr_m2 = reg_wr && reg_addr == `TIM_ADDR_MASK2;
  assign wr_m3 = reg_wr && reg_addr == `TIM_ADDR_MASK3;
  assign wr_rc = reg_wr && reg_addr == `TIM_ADDR_RESET_CTRL;

  // Mask registers and control bits
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mask1_q <= `TIM_MASK_RESET;
      mask2_q <= `TIM_MASK_RESET;
      mask3_q <= `TIM_MASK_RESET;
      irq_suspend_q <= 1'b0;
      irq_acknowledge_q <= 1'b0;
    end
    else
    begin
      if (wr_m1)
        mask1_q <= reg_wdata & `TIM_MASK1_USED;
      if (wr_m2)
        mask2_q <= reg_wdata;
      if (wr_m3)
        mask3_q <= reg_wdata & `TIM_MASK3_USED;
      // Acknowledge is a one-cycle strobe
      irq_acknowledge_q <= wr_rc && reg_wdata[`TIM_BIT_ACK];
      if (wr_rc)
        irq_suspend_q <= reg_wdata[`TIM_BIT_SUSPEND];
    end
  end

  // Readback; the acknowledge bit always reads as zero
  always_comb
  begin
    case (reg_addr)
      `TIM_ADDR_MASK1: reg_rdata = mask1_q;
      `TIM_ADDR_MASK2: reg_rdata = mask2_q;
      `TIM_ADDR_MASK3: reg_rdata = mask3_q;
      `TIM_ADDR_RESET_CTRL:
        reg_rdata = {1'b0, irq_suspend_q, 6'h00};
      default: reg_rdata = 8'h00;
    endcase
    if (!reg_rd)
      reg_rdata = 8'h00;
  end

  // Error and multiframe counters, wrap sensed on FFH to 00H
  assign cnt_inc = {err_cnt_inc, test_seq_mf_inc, mf_sync_loss_inc};
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 8; i++)
      if (srst || cnt_clear)
        cnt_q[i] <= '0;
      else if (cnt_inc[i])
        cnt_q[i] <= cnt_q[i] + 1'b1;
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      cnt_wrap[i] = cnt_inc[i] && !cnt_clear && (&cnt_q[i]);
  end

  // Pulse density: fewer than N ones in 8(N+1) bits
  always_ff @(posedge clk_sys)
  begin
    if (srst || dens_viol || (density_bit && dens_bits_q ==
        8'(({3'h0, density_n} + 8'h01) << 3) - 8'h01))
    begin
      dens_ones_q <= 5'h00;
      dens_bits_q <= 8'h00;
    end
    else if (density_bit)
    begin
      dens_bits_q <= dens_bits_q + 8'h01;
      // Saturate: a long window holds more ones than five bits can count
      if (density_one && dens_ones_q != 5'h1f)
        dens_ones_q <= dens_ones_q + 5'h01;
    end
  end
  // Window end reached with too few ones; N of 0 or above 23 disables
  assign dens_viol = density_bit && density_n != 5'h00 &&
    density_n <= 5'(`TIM_PD_MAX_N) &&
    dens_bits_q == 8'(({3'h0, density_n} + 8'h01) << 3) - 8'h01 &&
    ({1'b0, dens_ones_q} + {5'h00, density_one}) < {1'b0, density_n};

  // Timer rising edges
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      one_sec_q <= 1'b0;
      five_sec_q <= 1'b0;
    end
    else
    begin
      one_sec_q <= one_second_tick;
      five_sec_q <= five_second_tick;
    end
  end
  assign one_sec_rise = one_second_tick && !one_sec_q;
  assign five_sec_rise = five_second_tick && !five_sec_q;

  // Loop code persistence timer, fires once per continuous detection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lc_q <= TIM_LC_IDLE;
      lc_cnt_q <= 32'h0;
    end
    else
    begin
      case (lc_q)
        TIM_LC_IDLE:
        begin
          lc_cnt_q <= 32'h1;
          if (loop_code_seen)
            lc_q <= TIM_LC_TIMING;
        end
        TIM_LC_TIMING:
        begin
          if (!loop_code_seen)
            lc_q <= TIM_LC_IDLE;
          else if (lc_cnt_q >= 32'(LOOP_CYCLES) - 32'h1)
            lc_q <= TIM_LC_DONE;
          else
            lc_cnt_q <= lc_cnt_q + 32'h1;
        end
        TIM_LC_DONE:
          if (!loop_code_seen)
            lc_q <= TIM_LC_IDLE;
        default: lc_q <= TIM_LC_IDLE;
      endcase
    end
  end
  assign loop_fire = lc_q == TIM_LC_TIMING && loop_code_seen &&
    lc_cnt_q >= 32'(LOOP_CYCLES) - 32'h1;

  // Message acceptance filter
  tim_bom_filter u_bom (
    .clk_sys(clk_sys),
    .srst(srst),
    .msg_valid(msg_valid),
    .msg_code(msg_code),
    .new_msg(bom_new)
  );

  // Raw events in mask bit order
  assign ev1 = {frame_bit_err && term_frame_sync,
                check_err,
                remote_alarm,
                align_change,
                bipolar_viol && !bipolar_subst,
                test_seq_err,
                zeros_excess || dens_viol,
                1'b0};
  assign ev2 = cnt_wrap;
  assign ev3 = {3'h0, loop_fire, one_sec_rise, five_sec_rise, bom_new,
                signaling_debounce_en ? signaling_change_db
                                      : signaling_change};

  // Pending flags: masked and suspended events ignored; a new event wins
  // over acknowledge so nothing arriving in that cycle is lost
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pend1_q <= 8'h00;
      pend2_q <= 8'h00;
      pend3_q <= 8'h00;
    end
    else if (irq_suspend_q)
    begin
      pend1_q <= irq_acknowledge_q ? 8'h00 : pend1_q;
      pend2_q <= irq_acknowledge_q ? 8'h00 : pend2_q;
      pend3_q <= irq_acknowledge_q ? 8'h00 : pend3_q;
    end
    else
    begin
      pend1_q <= (irq_acknowledge_q ? 8'h00 : pend1_q) | (ev1 & mask1_q);
      pend2_q <= (irq_acknowledge_q ? 8'h00 : pend2_q) | (ev2 & mask2_q);
      pend3_q <= (irq_acknowledge_q ? 8'h00 : pend3_q) | (ev3 & mask3_q);
    end
  end

  // Open drain: drive low only when pending and not suspended
  assign pending = |{pend1_q, pend2_q, pend3_q};
  assign irq_n_o = 1'b0;
  assign irq_n_oe = pending && !irq_suspend_q;
endmodule : tim_irq_masks
`default_nettype wire

// *** tim_host.sv ***
// Host processor model for the parallel register port
`timescale 1ns/1ps
`default_nettype none
module tim_host
  import tim_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [4:0] reg_addr = 5'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00
);
  // One-cycle strobe; data is scrambled once taken, never left stale
  task automatic wr(input logic [4:0] a, input tim_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // Read data is combinational, so it is taken at the closing edge
  task automatic rd(input logic [4:0] a, output tim_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    d = reg_rdata;
    reg_rd <= 1'b0;
  endtask : rd
endmodule : tim_host
`default_nettype wire

// *** tim_irq_masks_checker.sv ***
// Port-level checker for the interrupt masks
`timescale 1ns/1ps
`default_nettype none
`include "tim_cfg.svh"
module tim_irq_masks_checker
  import tim_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic frame_bit_err,
  input wire logic term_frame_sync,
  input wire logic one_second_tick,
  input wire logic irq_n_o,
  input wire logic irq_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  tim_byte_t m1_q, m2_q, m3_q;
  logic susp_q;
  // Shadow masks, since the checker cannot see the registers
  wire w1a = reg_wr && reg_addr == `TIM_ADDR_RESET_CTRL;
  wire m_zero = m1_q == 8'h00 && m2_q == 8'h00 && m3_q == 8'h00;
  wire only_fe = m1_q[6:0] == 7'h00 && m2_q == 8'h00 && m3_q == 8'h00;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      m1_q <= 8'h00;
      m2_q <= 8'h00;
      m3_q <= 8'h00;
      susp_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TIM_ADDR_MASK1) m1_q <= reg_wdata;
      if (reg_addr == `TIM_ADDR_MASK2) m2_q <= reg_wdata;
      if (reg_addr == `TIM_ADDR_MASK3) m3_q <= reg_wdata;
      if (w1a) susp_q <= reg_wdata[`TIM_BIT_SUSPEND];
    end
  end
  a_pin_drives_low: assert property (irq_n_oe |-> !irq_n_o)
    else $error("interrupt pin not driven low");
  a_idle_read_zero: assert property (!reg_rd |-> reg_rdata == 8'h00)
    else $error("read data without read enable");
  a_all_masked: assert property (!irq_n_oe && m_zero && !w1a |=> !irq_n_oe)
    else $error("interrupt with all masks clear");
  a_frame_err_irq: assert property (frame_bit_err && term_frame_sync
    && m1_q[7] && !susp_q && !w1a |=> irq_n_oe)
    else $error("framing error did not interrupt");
  a_frame_no_sync: assert property (!irq_n_oe && only_fe && !w1a
    && frame_bit_err && !term_frame_sync |=> !irq_n_oe)
    else $error("framing error out of sync interrupted");
  a_ack_release: assert property (w1a && reg_wdata[`TIM_BIT_ACK]
    && only_fe ##1 !frame_bit_err |=> !irq_n_oe)
    else $error("acknowledge did not release pin");
  a_irq_stands: assert property (irq_n_oe && !w1a && !$past(w1a)
    |=> irq_n_oe)
    else $error("interrupt dropped without acknowledge");
  a_suspend_quiet: assert property (susp_q |-> !irq_n_oe)
    else $error("interrupt while suspended");
  a_second_rise: assert property ($rose(one_second_tick) && m3_q[3]
    && !susp_q && !w1a |=> irq_n_oe)
    else $error("second tick did not interrupt");
  c_ack: cover property (irq_n_oe ##1 w1a);
  c_susp: cover property (susp_q && frame_bit_err);
  c_irq: cover property ($rose(irq_n_oe));
endmodule : tim_irq_masks_checker
bind tim_irq_masks tim_irq_masks_checker u_chk (.clk_sys, .srst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .frame_bit_err,
  .term_frame_sync, .one_second_tick, .irq_n_o, .irq_n_oe);
`default_nettype wire

// *** tim_irq_masks_tb_top.sv ***
// Self-checking testbench for the interrupt masks
`timescale 1ns/1ps
`default_nettype none
`include "tim_cfg.svh"
module tim_irq_masks_tb_top
  import tim_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sync = 1'b1;
  logic subst = 1'b0;
  logic db_en = 1'b0;
  logic loop = 1'b0;
  logic [1:0] tk = 2'h0;
  logic [18:0] pl = 19'h00000;
  logic [5:0] code = 6'h00;
  logic [4:0] dens_n = 5'h00;
  logic dens_bit = 1'b0;
  logic dens_one = 1'b0;
  logic [4:0] reg_addr;
  logic reg_wr, reg_rd, irq_n_o, irq_n_oe;
  tim_byte_t reg_wdata, reg_rdata, d;
  tim_byte_t used [3] = '{8'hfe, 8'hff, 8'h1f};
  int failures = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  // Short loop timer keeps the run brief
  tim_irq_masks #(.LOOP_CYCLES(20)) DUT (.clk_sys, .srst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .frame_bit_err(pl[7]),
    .term_frame_sync(sync), .check_err(pl[6]), .remote_alarm(pl[5]),
    .align_change(pl[4]), .bipolar_viol(pl[3]), .bipolar_subst(subst),
    .test_seq_err(pl[2]), .zeros_excess(pl[1]), .density_n(dens_n),
    .density_one(dens_one), .density_bit(dens_bit),
    .err_cnt_inc(pl[15:10]),
    .test_seq_mf_inc(pl[9]), .mf_sync_loss_inc(pl[8]), .cnt_clear(1'b0),
    .loop_code_seen(loop), .one_second_tick(tk[1]),
    .five_second_tick(tk[0]), .msg_valid(pl[16]), .msg_code(code),
    .signaling_change(pl[17]), .signaling_change_db(pl[18]),
    .signaling_debounce_en(db_en), .irq_n_o, .irq_n_oe);
  tim_host HOST (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata);
  task automatic chk(input tim_byte_t g, input tim_byte_t e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One-cycle event pulses on the selected inputs
  task automatic pulse(input logic [18:0] v);
    @(posedge clk_sys);
    pl <= v;
    @(posedge clk_sys);
    pl <= 19'h00000;
  endtask : pulse
  task automatic expi(input logic e);
    @(posedge clk_sys);
    chk({7'h00, irq_n_oe}, {7'h00, e});
  endtask : expi
  // Strobe lands one edge after the write, so wait one more
  task automatic ack;
    HOST.wr(`TIM_ADDR_RESET_CTRL, 8'h20);
    @(posedge clk_sys);
    expi(1'b0);
  endtask : ack
  task automatic conclude;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    // Reset values, unused bits, unmapped address
    for (int i = 0; i < 3; i++)
    begin
      HOST.rd(`TIM_ADDR_MASK1 + 5'(i), d);
      chk(d, 8'h00);
      HOST.wr(`TIM_ADDR_MASK1 + 5'(i), 8'hff);
      HOST.rd(`TIM_ADDR_MASK1 + 5'(i), d);
      chk(d, used[i]);
      HOST.wr(`TIM_ADDR_MASK1 + 5'(i), 8'h00);
    end
    HOST.rd(5'h05, d);
    chk(d, 8'h00);
    $display("done: registers");
    // Each line event, masked by its own bit only, then enabled
    for (int b = 1; b < 8; b++)
    begin
      HOST.wr(`TIM_ADDR_MASK1, 8'hfe ^ (8'h01 << b));
      pulse(19'h00001 << b);
      expi(1'b0);
      HOST.wr(`TIM_ADDR_MASK1, 8'h01 << b);
      pulse(19'h00001 << b);
      expi(1'b1);
      ack();
    end
    // Density, N of 1: a window with one 1 passes, an all-zero one fails
    HOST.wr(`TIM_ADDR_MASK1, 8'h02);
    dens_n <= 5'h01;
    dens_bit <= 1'b1;
    dens_one <= 1'b1;
    @(posedge clk_sys);
    dens_one <= 1'b0;
    repeat (15) @(posedge clk_sys);
    expi(1'b0);
    repeat (15) @(posedge clk_sys);
    dens_bit <= 1'b0;
    expi(1'b1);
    ack();
    // N of 23 with all ones: more ones than the counter width holds
    dens_n <= 5'h17;
    dens_one <= 1'b1;
    dens_bit <= 1'b1;
    repeat (192) @(posedge clk_sys);
    dens_bit <= 1'b0;
    expi(1'b0);
    sync <= 1'b0;
    subst <= 1'b1;
    HOST.wr(`TIM_ADDR_MASK1, 8'h88);
    pulse(19'h00088);
    expi(1'b0);
    sync <= 1'b1;
    subst <= 1'b0;
    HOST.wr(`TIM_ADDR_RESET_CTRL, 8'h40);
    pulse(19'h00080);
    expi(1'b0);
    HOST.wr(`TIM_ADDR_RESET_CTRL, 8'h00);
    expi(1'b0);
    $display("done: line events");
    // Counter wraps need exactly 256 increments
    for (int b = 0; b < 8; b++)
    begin
      HOST.wr(`TIM_ADDR_MASK2, 8'h01 << b);
      repeat (255) pulse(19'h00100 << b);
      expi(1'b0);
      pulse(19'h00100 << b);
      expi(1'b1);
      ack();
    end
    $display("done: counters");
    HOST.wr(`TIM_ADDR_MASK3, 8'h0c);
    for (int i = 0; i < 2; i++)
    begin
      tk[i] <= 1'b1;
      @(posedge clk_sys);
      expi(1'b1);
      ack();
      expi(1'b0);
      tk[i] <= 1'b0;
    end
    HOST.wr(`TIM_ADDR_MASK3, 8'h10);
    loop <= 1'b1;
    repeat (10) @(posedge clk_sys);
    loop <= 1'b0;
    expi(1'b0);
    loop <= 1'b1;
    repeat (30) @(posedge clk_sys);
    expi(1'b1);
    loop <= 1'b0;
    ack();
    HOST.wr(`TIM_ADDR_MASK3, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      db_en <= i[0];
      pulse(19'h40000 >> i);
      expi(1'b0);
      pulse(19'h20000 << i);
      expi(1'b1);
      ack();
    end
    $display("done: timers, loop code, signaling");
    code <= 6'h15;
    HOST.wr(`TIM_ADDR_MASK3, 8'h02);
    // Filter output is registered, so each check waits one edge more
    repeat (7) pulse(19'h10000);
    @(posedge clk_sys);
    expi(1'b0);
    pulse(19'h10000);
    @(posedge clk_sys);
    expi(1'b1);
    ack();
    repeat (2) pulse(19'h10000);
    @(posedge clk_sys);
    expi(1'b0);
    code <= 6'h2a;
    repeat (8) pulse(19'h10000);
    @(posedge clk_sys);
    expi(1'b1);
    ack();
    $display("done: messages");
    conclude();
  end
endmodule : tim_irq_masks_tb_top
`default_nettype wire
